// ---- sim/nfc_flash_model.sv ----
// Behavioural model of the NOR flash device as seen at its pins
`default_nettype none
module nfc_flash_model #(
    parameter logic [2:0] SEL_CODE = 3'h0, // Chip select levels that select the part
    parameter int         BUSY_NS  = 2000  // Program time, shortened for the run
) (
    input  wire logic [23:0] addr_i,   // Address pins
    input  wire logic [15:0] dq_i,     // Data driven by the host
    output var  logic [15:0] dq_o,     // Data pins as the host sees them
    input  wire logic [2:0]  cs_i,     // Chip selects
    input  wire logic        we_n_i,   // Write strobe
    input  wire logic        oe_n_i,   // Output enable
    input  wire logic        byte_n_i, // Width select
    input  wire logic        rp_n_i,   // Reset/power-down
    output var  logic        sts_o     // Status output pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [22:0]];
    logic        sel;
    logic        busy = 1'b0;
    logic        prog_arm = 1'b0;
    logic        show_sr = 1'b0;
    logic [15:0] rd_val;
    logic [15:0] last_q = 16'h0000;
    ////////////////////////////////////////
    // Deselected or in power-down the part ignores its pins
    assign sel = (cs_i == SEL_CODE) && rp_n_i;
    // Ready/busy level; power-down does not clear busy, only prog_arm and show_sr
    assign sts_o = !busy;
    // Word index from A[23:1]; in x8 the lowest bit picks the byte
    always @* begin
        rd_val = mem.exists(addr_i[23:1]) ? mem[addr_i[23:1]] : 16'hFFFF;
        if (show_sr) begin
            rd_val = {8'h00, !busy, 7'h00};
        end else if (!byte_n_i) begin
            rd_val = {8'h00, addr_i[0] ? rd_val[15:8] : rd_val[7:0]};
        end
    end
    // Released pins show the inverse of the last value, never a held copy
    always @* begin
        if (sel && !oe_n_i) begin
            dq_o = rd_val;
            last_q = rd_val;
        end else begin
            dq_o = ~last_q;
        end
    end
    // Commands are taken on the rising write strobe, then run unaided
    always @(posedge we_n_i or negedge rp_n_i) begin
        if (!rp_n_i) begin
            prog_arm <= 1'b0;
            show_sr <= 1'b0;
        end else if (sel && !busy) begin
            if (prog_arm) begin
                mem[addr_i[23:1]] = dq_i;
                prog_arm <= 1'b0;
                show_sr <= 1'b1;
                busy <= 1'b1;
                busy <= #(BUSY_NS) 1'b0;
            end else if (dq_i[7:0] == 8'h40) begin
                prog_arm <= 1'b1;
            end else if (dq_i[7:0] == 8'h70) begin
                show_sr <= 1'b1;
            end else if (dq_i[7:0] == 8'hFF) begin
                show_sr <= 1'b0;
            end
        end
    end
endmodule : nfc_flash_model
`default_nettype wire

// ---- sim/tb_nor_flash_command_control.sv ----
// Self-checking bench for the flash command controller and device model
`default_nettype none
module tb_nor_flash_command_control import nfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, cs;
    logic [23:0] fa;
    logic [15:0] dqo, dqi;
    logic        dqoe, we_n, oe_n, byte_n, rp_n, sts;
    int          err_total, n_compared;
    ////////////////////////////////////////
    nfc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .flash_addr_o(fa), .flash_dq_o(dqo), .flash_dq_oe(dqoe), .flash_dq_i(dqi),
        .flash_cs_o(cs), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n),
        .flash_rp_n(rp_n), .status_output_pin_i(sts));
    nfc_flash_model flash (.addr_i(fa), .dq_i(dqo), .dq_o(dqi), .cs_i(cs),
        .we_n_i(we_n), .oe_n_i(oe_n), .byte_n_i(byte_n), .rp_n_i(rp_n), .sts_o(sts));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One single word transfer; read data is taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    // Poll a status bit under a bound, so a stuck flag cannot hang the run
    task automatic wait_st(input int b, input logic v);
        int k;
        k = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000);
            k++;
        end while (rd[b] !== v && k < 4000);
        chk("status poll", {31'h0, rd[b]}, {31'h0, v});
    endtask : wait_st
    task automatic run_op(input logic [31:0] ctrl);
        bus(1'b1, OFS_CTRL, ctrl);
        wait_st(S_DONE, 1'b1);
        bus(1'b1, OFS_STATUS, 32'h0000_0010);
    endtask : run_op
    ////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", rd, CTRL_RST);
        chk("rp_n at reset", {31'h0, rp_n}, 32'h0000_0000);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status reset", rd & 32'h0000_000F, 32'h0000_0002);
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    // Wake the part in x16 and program one word as a command pair
    task automatic t_program();
        bus(1'b1, OFS_CTRL, 32'h0000_0008);
        wait_st(S_WROK, 1'b1);
        chk("width pin", {31'h0, byte_n}, 32'h0000_0001);
        bus(1'b1, OFS_CMD, 32'h0000_0040);
        bus(1'b1, OFS_WDATA, 32'h0000_1234);
        bus(1'b1, OFS_ADDR, 32'h0000_0102);
        run_op(32'h0000_000E);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("pin busy", {31'h0, rd[S_PIN]}, 32'h0000_0000);
        wait_st(S_PIN, 1'b1);
        chk("pulse seen", {31'h0, rd[S_PULSE]}, 32'h0000_0001);
        bus(1'b1, OFS_STATUS, 32'h0000_0020);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("flags cleared", rd & 32'h0000_0030, 32'h0000_0000);
        $display("test program done");
    endtask : t_program
    // Read back in x16 with bit zero set, then both bytes in x8
    task automatic t_read();
        bus(1'b1, OFS_WDATA, 32'h0000_00FF);
        run_op(32'h0000_000D);
        bus(1'b1, OFS_ADDR, 32'h0000_0103);
        run_op(32'h0000_000C);
        chk("a0 in x16", {31'h0, fa[0]}, 32'h0000_0000);
        bus(1'b0, OFS_RDATA, 32'h0000_0000);
        chk("x16 word", rd, 32'h0000_1234);
        run_op(32'h0000_0004);
        bus(1'b0, OFS_RDATA, 32'h0000_0000);
        chk("x8 high byte", rd, 32'h0000_0012);
        bus(1'b1, OFS_ADDR, 32'h0000_0102);
        run_op(32'h0000_0004);
        bus(1'b0, OFS_RDATA, 32'h0000_0000);
        chk("x8 low byte", rd, 32'h0000_0034);
        bus(1'b1, OFS_WDATA, 32'h0000_0070);
        run_op(32'h0000_0005);
        run_op(32'h0000_0004);
        bus(1'b0, OFS_RDATA, 32'h0000_0000);
        chk("status word", rd, 32'h0000_0080);
        $display("test read done");
    endtask : t_read
    // Deselect, then power down and see reads and writes refused in the status
    task automatic t_power();
        bus(1'b1, OFS_CTRL, 32'h0000_0700);
        // The write lands at the edge the task returns on; look one cycle on
        @(posedge hclk);
        chk("selects", {29'h0, cs}, 32'h0000_0007);
        bus(1'b1, OFS_CTRL, 32'h0000_0010);
        @(posedge hclk);
        chk("rp_n low", {31'h0, rp_n}, 32'h0000_0000);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("power-down status", rd & 32'h0000_000E, 32'h0000_0002);
        $display("test power done");
    endtask : t_power
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_program();
        t_read();
        t_power();
        close_out();
    end
    // Whole run needs well under 20000 cycles
    initial begin
        #(25 * 20000);
        err_total++;
        close_out();
    end
endmodule : tb_nor_flash_command_control
`default_nettype wire

// ---- src/nfc_ctrl.sv ----
// AHB-Lite controlled host sequencer for an asynchronous NOR flash
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`default_nettype none
module nfc_ctrl
    import nfc_pkg::*;
(
    input  wire logic        hclk,          // Bus clock
    input  wire logic        hresetn,       // Async reset, active low
    input  wire logic        hsel,          // Slave select
    input  wire logic [31:0] haddr,         // Byte address
    input  wire logic [1:0]  htrans,        // Transfer type
    input  wire logic        hwrite,        // Write when high
    input  wire logic [2:0]  hsize,         // Transfer size
    input  wire logic [31:0] hwdata,        // Write data
    input  wire logic        hready,        // Bus ready
    output var  logic [31:0] hrdata,        // Read data
    output var  logic        hreadyout,     // Always ready
    output var  logic        hresp,         // Always OKAY
    output var  logic [23:0] flash_addr_o,  // Flash address pins
    output var  logic [15:0] flash_dq_o,    // Data pins, driven value
    output var  logic        flash_dq_oe,   // Data pins driven when high
    input  wire logic [15:0] flash_dq_i,    // Data pins, sampled value
    output var  logic [2:0]  flash_cs_o,    // Chip select levels
    output var  logic        flash_we_n,    // Write strobe, active low
    output var  logic        flash_oe_n,    // Output enable, active low
    output var  logic        flash_byte_n,  // Width select, high for x16
    output var  logic        flash_rp_n,    // Reset/power-down, active low
    input  wire logic        status_output_pin_i // Ready/busy or pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic [31:0] ctrl_q;
    logic [23:0] addr_q;
    logic [15:0] wdata_q;
    logic [7:0]  cmd_q;
    logic [15:0] rdata_q;
    logic        pending_q;
    logic        done_q;
    logic        pulse_q;
    logic        sts_prev_q;
    logic [11:0] wake_cnt_q;
    logic [11:0] cnt_q;
    logic        rd_q;
    logic        second_q;
    logic        wr_ph_q;
    logic [7:0]  a_ph_q;
    logic [31:0] hrdata_q;
    nfc_state_t  state_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    wire logic addr_ph = hsel & hready & htrans[1];
    wire logic rd_ok   = flash_rp_n & (wake_cnt_q >= REC_CYC);
    wire logic wr_ok   = flash_rp_n & (wake_cnt_q == WAKE_CYC);
    wire logic busy    = (state_q != ST_IDLE) | pending_q;
    wire logic wr_en   = wr_ph_q;
    wire logic [31:0] status_v = {26'h000_0000, pulse_q, done_q, wr_ok, rd_ok,
                                  sts_prev_q, busy};

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Capture the address phase; read data is latched then so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_q  <= 1'b0;
            a_ph_q   <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_ph_q <= addr_ph & hwrite;
            if (addr_ph) begin
                a_ph_q <= haddr[7:0];
            end
            if (addr_ph & !hwrite) begin
                if (hit(haddr[7:0], OFS_CTRL)) begin
                    hrdata_q <= ctrl_q;
                end else if (hit(haddr[7:0], OFS_ADDR)) begin
                    hrdata_q <= {8'h00, addr_q};
                end else if (hit(haddr[7:0], OFS_WDATA)) begin
                    hrdata_q <= {16'h0000, wdata_q};
                end else if (hit(haddr[7:0], OFS_CMD)) begin
                    hrdata_q <= {24'h00_0000, cmd_q};
                end else if (hit(haddr[7:0], OFS_RDATA)) begin
                    hrdata_q <= {16'h0000, rdata_q};
                end else if (hit(haddr[7:0], OFS_STATUS)) begin
                    hrdata_q <= status_v;
                end else begin
                    hrdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // Writable registers; the go bit is self-clearing and is not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= CTRL_RST;
            addr_q  <= 24'h00_0000;
            wdata_q <= 16'h0000;
            cmd_q   <= 8'h00;
        end else if (wr_en) begin
            if (hit(a_ph_q, OFS_CTRL)) begin
                ctrl_q <= hwdata & 32'h0000_071B;
            end
            if (hit(a_ph_q, OFS_ADDR)) begin
                addr_q <= hwdata[23:0];
            end
            if (hit(a_ph_q, OFS_WDATA)) begin
                wdata_q <= hwdata[15:0];
            end
            if (hit(a_ph_q, OFS_CMD)) begin
                cmd_q <= hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset/power-down and wake timing
    assign flash_rp_n   = !ctrl_q[C_PWRDN];
    assign flash_byte_n = ctrl_q[C_X16];
    assign flash_cs_o   = ctrl_q[C_CS +: 3];

    // Counts from pin release; reads wait for recovery, writes for wake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_cnt_q <= 12'h000;
        end else if (ctrl_q[C_PWRDN]) begin
            wake_cnt_q <= 12'h000; // RQ19
        end else if (wake_cnt_q != WAKE_CYC) begin
            wake_cnt_q <= wake_cnt_q + 12'h001; // RQ19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status pin watch; a set in the same cycle as a clear wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_prev_q <= 1'b1;
            pulse_q    <= 1'b0;
        end else begin
            sts_prev_q <= status_output_pin_i;
            if (sts_prev_q & !status_output_pin_i) begin
                pulse_q <= 1'b1; // RQ13
            end else if (wr_en & hit(a_ph_q, OFS_STATUS) & hwdata[S_PULSE]) begin
                pulse_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request latch; a go while busy is ignored
    wire logic go_wr = wr_en & hit(a_ph_q, OFS_CTRL) & hwdata[C_GO];
    wire logic [1:0] op = ctrl_q[C_OP +: 2];
    wire logic launch = (state_q == ST_IDLE) & pending_q &
                        ((op == OP_READ) ? rd_ok : wr_ok);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_q <= 1'b0;
        end else if (launch) begin
            pending_q <= 1'b0;
        end else if (go_wr & !busy) begin
            pending_q <= 1'b1; // RQ3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sequencer: strobe for a fixed count, hold one cycle, optional second cycle
    wire logic [11:0] len = rd_q ? RD_CYC : WE_CYC;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 12'h000;
            rd_q       <= 1'b0;
            second_q   <= 1'b0;
            flash_dq_o <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (launch) begin
                        rd_q       <= (op == OP_READ);
                        second_q   <= (op == OP_PAIR); // RQ9
                        flash_dq_o <= (op == OP_PAIR) ? {8'h00, cmd_q} : wdata_q; // RQ3
                        cnt_q      <= 12'h000;
                        state_q    <= ST_ASSERT;
                    end
                end
                ST_ASSERT: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == len - 12'h001) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (second_q) begin
                        flash_dq_o <= wdata_q; // RQ9
                        second_q   <= 1'b0;
                        state_q    <= ST_NEXT;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_NEXT: begin
                    cnt_q   <= 12'h000;
                    state_q <= ST_ASSERT;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Read capture at the end of the access window; byte mode keeps the low lane
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 16'h0000;
        end else if (state_q == ST_ASSERT && rd_q && cnt_q == len - 12'h001) begin
            rdata_q <= ctrl_q[C_X16] ? flash_dq_i : {8'h00, flash_dq_i[7:0]};
        end
    end

    // Done flag: set at the end of a transfer, cleared by writing one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else if (state_q == ST_HOLD && !second_q) begin
            done_q <= 1'b1;
        end else if (wr_en & hit(a_ph_q, OFS_STATUS) & hwdata[S_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // Strobes decoded from the state register, whose HOLD to IDLE and NEXT to ASSERT steps change both bits
    assign flash_we_n   = !(state_q == ST_ASSERT && !rd_q);
    assign flash_oe_n   = !(state_q == ST_ASSERT && rd_q);
    assign flash_dq_oe  = (state_q != ST_IDLE) && !rd_q;
    assign flash_addr_o = {addr_q[23:1], addr_q[0] & !ctrl_q[C_X16]};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [11:0] low_cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_q <= 12'h000;
        end else begin
            low_cnt_q <= flash_we_n ? 12'h000 : low_cnt_q + 12'h001;
        end
    end

    sequence s_second_strobe;
        ##2 $fell(flash_we_n);
    endsequence

    a_wake_before_write: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
        !flash_we_n |-> (flash_rp_n && wake_cnt_q == WAKE_CYC))
        else $error("write strobe before wake time");
    a_recover_before_read: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
        !flash_oe_n |-> (flash_rp_n && wake_cnt_q >= REC_CYC))
        else $error("read before recovery time");
    a_strobe_width: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        $rose(flash_we_n) |-> low_cnt_q == WE_CYC)
        else $error("write strobe width wrong");
    a_data_steady: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        (!flash_we_n && $past(!flash_we_n)) |-> (flash_dq_oe && $stable(flash_dq_o)))
        else $error("data moved under write strobe");
    a_cmd_pair: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        ($rose(flash_we_n) && second_q) |-> s_second_strobe)
        else $error("second command cycle missing");
    a_pulse_seen: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
        (sts_prev_q && !status_output_pin_i) |=> pulse_q)
        else $error("status pulse not recorded");

    // Read strobe length, counted the same way as the write strobe
    logic [11:0] oe_cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_cnt_q <= 12'h000;
        end else begin
            oe_cnt_q <= flash_oe_n ? 12'h000 : oe_cnt_q + 12'h001;
        end
    end

    // One strobe at a time, so the data pins never fight the part
    a_one_strobe: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        !(!flash_we_n && !flash_oe_n))
        else $error("both strobes low");
    a_read_width: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        $rose(flash_oe_n) |-> oe_cnt_q == RD_CYC)
        else $error("read strobe width wrong");
    a_pins_released: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        !flash_oe_n |-> !flash_dq_oe)
        else $error("data pins driven during read");
    a_word_addr: assert property (@(posedge hclk) disable iff (!hresetn) // RQ16
        flash_byte_n |-> !flash_addr_o[0])
        else $error("address bit zero driven in word mode");
    // Completion must reach software even if a clear lands in the same cycle
    a_done_set: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
        (state_q == ST_HOLD && !second_q) |=> done_q)
        else $error("done flag not set after transfer");

endmodule : nfc_ctrl
`default_nettype wire

// ---- src/nfc_pkg.sv ----
// Constants, register map and timing for the NOR flash command controller
// Function
// (RQ1) Array is uniform 128-KB erase blocks
// (RQ2) Device holds 128-bit one-time protection register
// (RQ3) Host writes command sequence, device runs it
// (RQ4) Erase clears one addressed block only
// (RQ5) Erase suspend allows other-block reads, programs
// (RQ6) Program suspend allows other-block reads
// (RQ7) Write buffer holds 256 bytes or words
// (RQ8) Locked blocks refuse erase and program
// (RQ9) Host issues set-lock and clear-lock commands
// (RQ10) Status register reports operation completion
// (RQ11) Status pin defaults to ready/busy level
// (RQ12) Status pin high when idle or suspended
// (RQ13) Host may configure status pin pulse mode
// (RQ14) Three chip selects enable the device
// (RQ15) Byte mode uses lowest address bit
// (RQ16) Word mode ignores address bit zero
// (RQ17) Deselected and not reset means standby
// (RQ18) Reset pin low blocks writes, clears state; the model clears prog_arm and show_sr but leaves busy set
// (RQ19) Host waits recovery and wake after reset
`default_nettype none
package nfc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0C;
    localparam logic [7:0] OFS_RDATA  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Control fields
    localparam int C_OP     = 0;
    localparam int C_GO     = 2;
    localparam int C_X16    = 3;
    localparam int C_PWRDN  = 4;
    localparam int C_CS     = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0010;
    // Operation codes in the control register
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_PAIR  = 2'h2;
    // Status fields
    localparam int S_BUSY  = 0;
    localparam int S_PIN   = 1;
    localparam int S_RDOK  = 2;
    localparam int S_WROK  = 3;
    localparam int S_DONE  = 4;
    localparam int S_PULSE = 5;
    // Timing, in ns, and derived cycle counts at the 40 MHz bus clock
    localparam int CLK_MHZ    = 40;
    localparam int T_STROBE_NS = 60;
    localparam int T_ACCESS_NS = 120;
    localparam int T_RECOV_NS  = 30000;
    localparam int T_WAKE_NS   = 40000;
    localparam logic [11:0] WE_CYC   = 12'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] RD_CYC   = 12'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] REC_CYC  = 12'((T_RECOV_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] WAKE_CYC = 12'((T_WAKE_NS * CLK_MHZ + 999) / 1000);
    // Sequencer states, Gray coded along IDLE-ASSERT-HOLD-NEXT
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ASSERT = 2'b01,
        ST_HOLD   = 2'b11,
        ST_NEXT   = 2'b10
    } nfc_state_t;
endpackage : nfc_pkg
`default_nettype wire
